//--- rtl/slam_pkg.sv
/*
  Constants shared by the servo link alarm monitor: alarm numbers,
  detail codes, field widths and the consecutive-cycle and flat-byte-run limits.
  Assumes nothing of its surroundings.
*/
package slam_pkg;

  // ----------------------------------------------------------------
  // Field widths
  // ----------------------------------------------------------------
  localparam int UNIT_W  = 4;
  localparam int UNITS   = 16;
  localparam int AXID_W  = 8;
  localparam int FCNT_W  = 4;
  localparam int CODE_W  = 16;
  localparam int CNT_W   = 3;
  localparam int RUN_W   = 8;

  // ----------------------------------------------------------------
  // Alarm numbers and detail codes
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] ALM_PROC_TIME = 16'h0050;
  localparam logic [CODE_W-1:0] ALM_LINK      = 16'h0051;
  localparam logic [CODE_W-1:0] DET_NONE      = 16'h0000;
  localparam logic [CODE_W-1:0] DET_CRC1      = 16'h0000;
  localparam logic [CODE_W-1:0] DET_CRC2      = 16'h0001;
  localparam logic [CODE_W-1:0] DET_RXTIME    = 16'h0002;
  localparam logic [CODE_W-1:0] DET_UNCLASS   = 16'h0005;
  localparam logic [CODE_W-1:0] DET_CONNECT   = 16'h0006;
  localparam logic [7:0]        LOW_IDCHG     = 8'h03;
  localparam logic [7:0]        LOW_FRAMES    = 8'h04;
  localparam logic [7:0]        LOW_AXCONN    = 8'h07;
  localparam logic [7:0]        LOW_INITFAIL  = 8'h20;
  localparam logic [3:0]        STATION_NO    = 4'h0;

  // ----------------------------------------------------------------
  // Counting limits
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0]  CONSEC_LIMIT  = 3'h4;
  localparam logic [RUN_W-1:0]  FLAT_RUN_LIM  = 8'hFA;
  localparam logic [7:0]        BYTE_ZERO     = 8'h00;
  localparam logic [7:0]        BYTE_ONES     = 8'hFF;

  // Index of each consecutive-cycle counter
  localparam int CC_FRAMES  = 0;
  localparam int CC_UNCLASS = 1;
  localparam int CC_LINK    = 2;
  localparam int CC_NUM     = 3;

  typedef enum logic [0:0]
  {
    ALM_IDLE = 1'b0,
    ALM_HELD = 1'b1
  } slam_state_e;

endpackage : slam_pkg

//--- rtl/slam_id_mem.sv
/*
  Small store of the axis identifier of each drive unit, one entry per
  rotary switch number, with a registered read port.
  Assumes a single clock; read and write may occur in one cycle.
*/
`timescale 1ns/1ps
module slam_id_mem
  import slam_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              wrEn,
  input  wire logic [UNIT_W-1:0] wrAddr,
  input  wire logic [AXID_W-1:0] wrData,
  input  wire logic              rdEn,
  input  wire logic [UNIT_W-1:0] rdAddr,
  output logic      [AXID_W-1:0] rdData
);

  logic [AXID_W-1:0] store [UNITS];

  always_ff @(posedge clock)
  begin
    if (wrEn)
    begin
      store[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rdEn)
    begin
      rdData <= store[rdAddr];
    end
  end

endmodule : slam_id_mem

//--- rtl/slam_alarm_monitor.sv
/*
  Fault monitor for the controller end of the serial drive link.
  Watches per-cycle link events, turns them into a system alarm number
  with a four-digit detail and holds the first alarm until cleared.
  Assumes all event inputs come from logic on the same clock, each a
  one-cycle pulse, and cycleEnd pulses once per communication cycle.
*/
`timescale 1ns/1ps
module slam_alarm_monitor
  import slam_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              cycleEnd,
  input  wire logic              procTimeOver,
  input  wire logic              crcErrFirst,
  input  wire logic              crcErrSecond,
  input  wire logic              recvTimingErr,
  input  wire logic              unclassErr,
  input  wire logic              linkFrameErr,
  input  wire logic              rxByteValid,
  input  wire logic [7:0]        rxByte,
  input  wire logic              frameCountValid,
  input  wire logic [FCNT_W-1:0] frameCount,
  input  wire logic [FCNT_W-1:0] frameExpected,
  input  wire logic              initDone,
  input  wire logic              axisIdValid,
  input  wire logic [UNIT_W-1:0] axisIdUnit,
  input  wire logic [AXID_W-1:0] axisId,
  input  wire logic              initFail,
  input  wire logic [UNIT_W-1:0] initFailUnit,
  input  wire logic              axisConnErr,
  input  wire logic [UNIT_W-1:0] axisConnUnit,
  input  wire logic              alarmClear,
  output logic                   alarmValid,
  output logic      [CODE_W-1:0] alarmNumber,
  output logic      [CODE_W-1:0] alarmDetail
);

  // ----------------------------------------------------------------
  // Per-cycle error flags
  // ----------------------------------------------------------------
  logic              frameBadNow;
  logic [CC_NUM-1:0] hitNow;
  logic [CC_NUM-1:0] hit_reg;
  logic [CC_NUM-1:0] cycleHit;

  assign frameBadNow        = frameCountValid && (frameCount != frameExpected);
  assign hitNow[CC_FRAMES]  = frameBadNow;
  assign hitNow[CC_UNCLASS] = unclassErr;
  assign hitNow[CC_LINK]    = linkFrameErr;
  // An event in the closing cycle still counts for that cycle
  assign cycleHit           = hit_reg | hitNow;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      hit_reg <= '0;
    end
    else if (cycleEnd)
    begin
      hit_reg <= '0;
    end
    else
    begin
      hit_reg <= hit_reg | hitNow;
    end
  end

  // ----------------------------------------------------------------
  // Consecutive-cycle counters
  // ----------------------------------------------------------------
  logic [CC_NUM-1:0] ccReached;

  genvar gi;
  generate
    for (gi = 0; gi < CC_NUM; gi++)
    begin : g_consec
      logic [CNT_W-1:0] cnt_reg;
      logic [CNT_W-1:0] cnt_next;

      always_comb
      begin
        cnt_next = cnt_reg;
        if (cycleEnd)
        begin
          if (!cycleHit[gi])
          begin
            cnt_next = '0;
          end
          else if (cnt_reg != CONSEC_LIMIT)
          begin
            cnt_next = cnt_reg + 3'h1;
          end
        end
      end

      always_ff @(posedge clock or posedge reset)
      begin
        if (reset)
        begin
          cnt_reg <= '0;
        end
        else
        begin
          cnt_reg <= cnt_next;
        end
      end

      assign ccReached[gi] = cycleEnd && cycleHit[gi] && (cnt_next == CONSEC_LIMIT)
                             && (cnt_reg != CONSEC_LIMIT);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Received frame count digit
  // ----------------------------------------------------------------
  logic [3:0] frameDigit_reg;
  logic [3:0] frameDigit;

  // A mismatch in the closing cycle itself supplies the digit
  assign frameDigit = frameBadNow ? (frameCount - 4'h1) : frameDigit_reg;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      frameDigit_reg <= '0;
    end
    else if (frameBadNow)
    begin
      frameDigit_reg <= frameCount - 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Flat data run detector
  // ----------------------------------------------------------------
  logic [RUN_W-1:0] flatRun_reg;
  logic [7:0]       lastByte_reg;
  logic             byteFlat;
  logic             flatFire;

  assign byteFlat = (rxByte == BYTE_ZERO) || (rxByte == BYTE_ONES);
  assign flatFire = rxByteValid && byteFlat && (rxByte == lastByte_reg)
                    && (flatRun_reg == FLAT_RUN_LIM - 8'h1);

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      flatRun_reg  <= '0;
      lastByte_reg <= '0;
    end
    else if (rxByteValid)
    begin
      lastByte_reg <= rxByte;
      if (!byteFlat)
      begin
        flatRun_reg <= '0;
      end
      else if (rxByte != lastByte_reg || flatRun_reg == '0)
      begin
        flatRun_reg <= 8'h1;
      end
      else if (flatRun_reg != FLAT_RUN_LIM)
      begin
        flatRun_reg <= flatRun_reg + 8'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Axis identity check
  // ----------------------------------------------------------------
  logic              idChkPend_reg;
  logic [UNIT_W-1:0] idChkUnit_reg;
  logic [AXID_W-1:0] idChkVal_reg;
  logic [AXID_W-1:0] storedId;
  logic              idChanged;

  slam_id_mem u_idMem
  (
    .clock  (clock),
    .wrEn   (axisIdValid && !initDone),
    .wrAddr (axisIdUnit),
    .wrData (axisId),
    .rdEn   (axisIdValid && initDone),
    .rdAddr (axisIdUnit),
    .rdData (storedId)
  );

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      idChkPend_reg <= 1'b0;
      idChkUnit_reg <= '0;
      idChkVal_reg  <= '0;
    end
    else
    begin
      idChkPend_reg <= axisIdValid && initDone;
      if (axisIdValid)
      begin
        idChkUnit_reg <= axisIdUnit;
        idChkVal_reg  <= axisId;
      end
    end
  end

  assign idChanged = idChkPend_reg && (storedId != idChkVal_reg);

  // ----------------------------------------------------------------
  // Alarm selection
  // ----------------------------------------------------------------
  logic              candValid;
  logic [CODE_W-1:0] candNumber;
  logic [CODE_W-1:0] candDetail;

  always_comb
  begin
    candValid  = 1'b1;
    candNumber = ALM_LINK;
    candDetail = DET_NONE;
    if (ccReached[CC_LINK] || flatFire)
    begin
      candDetail = DET_CONNECT;
    end
    else if (ccReached[CC_FRAMES])
    begin
      candDetail = {STATION_NO, frameDigit, LOW_FRAMES};
    end
    else if (ccReached[CC_UNCLASS])
    begin
      candDetail = DET_UNCLASS;
    end
    else if (initFail)
    begin
      candDetail = {STATION_NO, initFailUnit, LOW_INITFAIL};
    end
    else if (idChanged)
    begin
      candDetail = {STATION_NO, idChkUnit_reg, LOW_IDCHG};
    end
    else if (axisConnErr)
    begin
      candDetail = {STATION_NO, axisConnUnit, LOW_AXCONN};
    end
    else if (crcErrFirst)
    begin
      candDetail = DET_CRC1;
    end
    else if (crcErrSecond)
    begin
      candDetail = DET_CRC2;
    end
    else if (recvTimingErr)
    begin
      candDetail = DET_RXTIME;
    end
    else if (procTimeOver)
    begin
      candNumber = ALM_PROC_TIME;
    end
    else
    begin
      candValid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // First-alarm latch
  // ----------------------------------------------------------------
  slam_state_e       state_reg;
  logic [CODE_W-1:0] number_reg;
  logic [CODE_W-1:0] detail_reg;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_reg  <= ALM_IDLE;
      number_reg <= '0;
      detail_reg <= '0;
    end
    else
    begin
      case (state_reg)
        ALM_IDLE:
        begin
          if (candValid)
          begin
            state_reg  <= ALM_HELD;
            number_reg <= candNumber;
            detail_reg <= candDetail;
          end
        end
        ALM_HELD:
        begin
          if (alarmClear)
          begin
            state_reg  <= ALM_IDLE;
            number_reg <= '0;
            detail_reg <= '0;
          end
        end
        default:
        begin
          state_reg <= ALM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      alarmValid  <= 1'b0;
      alarmNumber <= '0;
      alarmDetail <= '0;
    end
    else
    begin
      alarmValid  <= (state_reg == ALM_HELD);
      alarmNumber <= number_reg;
      alarmDetail <= detail_reg;
    end
  end

endmodule : slam_alarm_monitor

//--- sim/slam_alarm_monitor_chk.sv
/*
  Checker of the alarm outputs of the servo link alarm monitor.
  Assumes it is bound to slam_alarm_monitor and shares its clock and reset.
*/
`timescale 1ns/1ps
module slam_alarm_monitor_chk
  import slam_pkg::*;
(
  input wire logic              clock,
  input wire logic              reset,
  input wire logic              procTimeOver,
  input wire logic              crcErrSecond,
  input wire logic              recvTimingErr,
  input wire logic              initFail,
  input wire logic              axisConnErr,
  input wire logic [UNIT_W-1:0] axisConnUnit,
  input wire logic              alarmClear,
  input wire logic              alarmValid,
  input wire logic [CODE_W-1:0] alarmNumber,
  input wire logic [CODE_W-1:0] alarmDetail
);
  // ----------------------------------------------------------------
  // Output relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_number_legal: assert property (alarmValid |->
    (alarmNumber == ALM_PROC_TIME || alarmNumber == ALM_LINK)) else $error("bad number");
  a_station_zero: assert property (alarmDetail[15:12] == STATION_NO)
    else $error("station not zero");
  a_idle_clean: assert property (!alarmValid |->
    alarmNumber == DET_NONE && alarmDetail == DET_NONE) else $error("idle not zero");
  a_first_held: assert property (alarmValid ##1 alarmValid |->
    $stable(alarmNumber) && $stable(alarmDetail)) else $error("held alarm changed");
  a_clear_drop: assert property (alarmValid && alarmClear |->
    ##[1:2] !alarmValid) else $error("clear ignored");
  a_proc_cause: assert property ($rose(alarmValid) &&
    alarmNumber == ALM_PROC_TIME |-> $past(procTimeOver, 2)) else $error("0050 uncaused");
  a_crc2_cause: assert property ($rose(alarmValid) && alarmDetail == DET_CRC2
    |-> $past(crcErrSecond, 2)) else $error("0001 uncaused");
  a_timing_cause: assert property ($rose(alarmValid) && alarmDetail == DET_RXTIME
    |-> $past(recvTimingErr, 2)) else $error("0002 uncaused");
  a_conn_cause: assert property ($rose(alarmValid) && alarmDetail[7:0] == LOW_AXCONN
    |-> $past(axisConnErr, 2) && $past(axisConnUnit, 2) == alarmDetail[11:8])
    else $error("0x07 uncaused");
  a_init_cause: assert property ($rose(alarmValid) && alarmDetail[7:0] == LOW_INITFAIL
    |-> $past(initFail, 2)) else $error("0x20 uncaused");

  c_id_change: cover property ($rose(alarmValid) && alarmDetail[7:0] == LOW_IDCHG);
  c_frames: cover property ($rose(alarmValid) && alarmDetail[7:0] == LOW_FRAMES);
  c_connect: cover property ($rose(alarmValid) && alarmDetail == DET_CONNECT);
endmodule : slam_alarm_monitor_chk

//--- sim/slam_drive_model.sv
/*
  Drive unit model: one unit, rotary number 3, cycle of eight clocks.
  Assumes the bench asks for wrong frame counts or a changed axis ID.
*/
`timescale 1ns/1ps
module slam_drive_model
  import slam_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              badFrames,
  input  wire logic              changeId,
  output logic                   cycleEnd,
  output logic                   frameCountValid,
  output logic      [FCNT_W-1:0] frameCount,
  output logic      [FCNT_W-1:0] frameExpected,
  output logic                   axisIdValid,
  output logic      [UNIT_W-1:0] axisIdUnit,
  output logic      [AXID_W-1:0] axisId
);
  logic [2:0] phase_reg;
  logic [3:0] fc;

  always_ff @(negedge clock or posedge reset)
    if (reset)
      phase_reg <= 3'h0;
    else
      phase_reg <= phase_reg + 3'h1;

  assign fc = badFrames ? 4'h5 : 4'h3;
  assign frameCount = (phase_reg == 3'h2) ? fc : ~fc;
  assign frameExpected = 4'h3;
  assign frameCountValid = !reset && phase_reg == 3'h2;
  assign axisIdValid = !reset && phase_reg == 3'h4;
  assign axisIdUnit = 4'h3;
  assign axisId = changeId ? 8'h22 : 8'h11;
  assign cycleEnd = !reset && phase_reg == 3'h7;
endmodule : slam_drive_model

//--- sim/slam_alarm_monitor_tb.sv
/*
  Self-checking bench of the servo link alarm monitor with a drive model.
  Assumes the package constants and a 100 MHz clock.
*/
`timescale 1ns/1ps
module slam_alarm_monitor_tb
  import slam_pkg::*;
;
  logic clock, reset, procTimeOver, crcErrFirst, crcErrSecond, recvTimingErr;
  logic unclassErr, linkFrameErr, rxByteValid, initDone, initFail, axisConnErr;
  logic alarmClear, badFrames, changeId, cycleEnd, frameCountValid, axisIdValid;
  logic              alarmValid;
  logic [7:0]        rxByte;
  logic [AXID_W-1:0] axisId;
  logic [FCNT_W-1:0] frameCount, frameExpected;
  logic [UNIT_W-1:0] axisIdUnit, initFailUnit, axisConnUnit;
  logic [CODE_W-1:0] alarmNumber, alarmDetail;
  int                failures, checks, ticks;

  slam_alarm_monitor uut (.clock, .reset, .cycleEnd, .procTimeOver, .crcErrFirst,
    .crcErrSecond, .recvTimingErr, .unclassErr, .linkFrameErr, .rxByteValid, .rxByte,
    .frameCountValid, .frameCount, .frameExpected, .initDone, .axisIdValid, .axisIdUnit,
    .axisId, .initFail, .initFailUnit, .axisConnErr, .axisConnUnit, .alarmClear,
    .alarmValid, .alarmNumber, .alarmDetail);
  slam_drive_model drive (.clock, .reset, .badFrames, .changeId, .cycleEnd,
    .frameCountValid, .frameCount, .frameExpected, .axisIdValid, .axisIdUnit, .axisId);

  always #5 clock = ~clock;

  always @(posedge clock)
  begin
    ticks++;
    if (ticks == 5000)
    begin
      $display("BAD %0t timeout", $time);
      failures++;
      close_out();
    end
  end

  task automatic close_out;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic no_alarm;
    checks++;
    if (alarmValid !== 1'b0)
      $display("BAD %0t unexpected alarm", $time);
    if (alarmValid !== 1'b0)
      failures++;
  endtask : no_alarm

  task automatic expect_alarm(input logic [CODE_W-1:0] num, input logic [CODE_W-1:0] det);
    int n;
    n = 0;
    while (alarmValid !== 1'b1 && n < 60)
    begin
      @(negedge clock);
      n++;
    end
    checks++;
    if (alarmValid !== 1'b1 || alarmNumber !== num || alarmDetail !== det)
    begin
      failures++;
      $display("BAD %0t alarm %h/%h, wanted %h/%h", $time, alarmNumber, alarmDetail, num, det);
    end
    alarmClear = 1'b1;
    @(negedge clock);
    alarmClear = 1'b0;
    repeat (3) @(negedge clock);
    no_alarm();
  endtask : expect_alarm

  // Bits: conn, init fail, timing, crc2, crc1, process time
  task automatic pulse_ev(input logic [5:0] m);
    {axisConnErr, initFail, recvTimingErr, crcErrSecond, crcErrFirst, procTimeOver} = m;
    @(negedge clock);
    {axisConnErr, initFail, recvTimingErr, crcErrSecond, crcErrFirst, procTimeOver} = 6'h00;
  endtask : pulse_ev

  // Bits: bad frames, link error, unclassified error; link and unclassified for one cycle each, bad frames left set
  task automatic burst(input int n, input logic [2:0] m);
    repeat (n)
    begin
      @(posedge clock iff cycleEnd);
      @(negedge clock);
      {badFrames, linkFrameErr, unclassErr} = m;
      @(negedge clock);
      {linkFrameErr, unclassErr} = 2'h0;
    end
  endtask : burst

  task automatic t_singles;
    pulse_ev(6'h01);
    expect_alarm(ALM_PROC_TIME, DET_NONE);
    pulse_ev(6'h02);
    expect_alarm(ALM_LINK, DET_CRC1);
    pulse_ev(6'h04);
    expect_alarm(ALM_LINK, DET_CRC2);
    pulse_ev(6'h08);
    expect_alarm(ALM_LINK, DET_RXTIME);
    pulse_ev(6'h10);
    expect_alarm(ALM_LINK, {STATION_NO, 4'h5, LOW_INITFAIL});
    pulse_ev(6'h20);
    expect_alarm(ALM_LINK, {STATION_NO, 4'h9, LOW_AXCONN});
  endtask : t_singles

  task automatic t_held;
    pulse_ev(6'h04);
    repeat (4) @(negedge clock);
    pulse_ev(6'h01);
    expect_alarm(ALM_LINK, DET_CRC2);
    pulse_ev(6'h3E);
    expect_alarm(ALM_LINK, {STATION_NO, 4'h5, LOW_INITFAIL});
  endtask : t_held

  task automatic t_consec;
    burst(3, 3'h1);
    burst(1, 3'h0);
    burst(3, 3'h1);
    no_alarm();
    burst(1, 3'h1);
    expect_alarm(ALM_LINK, DET_UNCLASS);
    burst(4, 3'h3);
    expect_alarm(ALM_LINK, DET_CONNECT);
    burst(4, 3'h4);
    expect_alarm(ALM_LINK, {STATION_NO, 4'h4, LOW_FRAMES});
    burst(1, 3'h0);
    burst(4, 3'h6);
    expect_alarm(ALM_LINK, DET_CONNECT);
    burst(1, 3'h0);
  endtask : t_consec

  task automatic t_flat;
    rxByteValid = 1'b1;
    rxByte = BYTE_ONES;
    repeat (249) @(negedge clock);
    rxByte = BYTE_ZERO;
    repeat (249) @(negedge clock);
    no_alarm();
    @(negedge clock);
    rxByteValid = 1'b0;
    expect_alarm(ALM_LINK, DET_CONNECT);
  endtask : t_flat

  task automatic t_idchg;
    initDone = 1'b1;
    burst(3, 3'h0);
    no_alarm();
    changeId = 1'b1;
    burst(1, 3'h0);
    changeId = 1'b0;
    expect_alarm(ALM_LINK, {STATION_NO, 4'h3, LOW_IDCHG});
  endtask : t_idchg

  initial
  begin
    {clock, procTimeOver, crcErrFirst, crcErrSecond, recvTimingErr, unclassErr} = 6'h00;
    {linkFrameErr, rxByteValid, initDone, initFail, axisConnErr, alarmClear} = 6'h00;
    {badFrames, changeId, rxByte} = 10'h000;
    initFailUnit = 4'h5;
    axisConnUnit = 4'h9;
    failures = 0;
    checks = 0;
    ticks = 0;
    reset = 1'b1;
    repeat (5) @(negedge clock);
    reset = 1'b0;
    t_singles();
    t_held();
    t_consec();
    t_flat();
    t_idchg();
    close_out();
  end
endmodule : slam_alarm_monitor_tb

bind slam_alarm_monitor slam_alarm_monitor_chk chk (.clock, .reset, .procTimeOver,
  .crcErrSecond, .recvTimingErr, .initFail, .axisConnErr, .axisConnUnit, .alarmClear,
  .alarmValid, .alarmNumber, .alarmDetail);
